//--- hdl/sti_defs.vh
// constants for the skip-test instruction decoder
// Overview of operation
// - Word 10'b1010000111 is the skip on the conversion done flag.
// - Enable bit clear and done flag set make that skip skip the next word.
// - A skip taken by it clears the done flag unless the converter sets it in that cycle; a clear flag runs the next.
// - With the enable bit set that skip is a no-op that keeps the flag.
// - The enable bit is bit 2 of the second interrupt control register.
// - Word 10'b0000111010 is the skip on the ext0 interrupt pin level.
// - Polarity bit clear: the pin skip skips when the pin is low.
// - Polarity bit set: the pin skip skips when high, runs when low.
`ifndef STI_DEFS_VH
`define STI_DEFS_VH
`define STI_OP_SKIP_CONV 10'h287
`define STI_OP_SKIP_EXT0 10'h03a
`define STI_CONV_IRQ_EN_BIT 2
`define STI_EXT0_POL_BIT 2
`endif

//--- hdl/sti_skip_decode.v
// skip-test instruction decoder and executor
`timescale 1ns/1ps
`default_nettype none
`include "sti_defs.vh"
module sti_skip_decode (
	// clock and reset
	input wire clk_sys,
	input wire nrst,
	// instruction stream, one word per machine cycle
	input wire instr_valid,
	input wire [9:0] instr_word,
	// core state consulted by the skips
	input wire [3:0] interrupt_control_reg_two,
	input wire [3:0] ext0_control_reg,
	input wire ext0_interrupt_pin,
	input wire conversion_done_set,
	// results
	output reg conversion_done_flag,
	output reg skip_next,
	output reg slot_squash,
	output reg decode_hit
);

	// kinds of word this block recognises
	localparam KIND_NONE = 2'b00;
	localparam KIND_CONV = 2'b01;
	localparam KIND_EXT0 = 2'b10;

	// control bits consulted by the two skips
	wire conversion_irq_enable_bit;
	wire ext0_polarity_bit;

	// slot qualification
	wire live;

	// decoded kind of the word in this slot
	reg [1:0] kind;

	// one-hot views of the decoded kind
	wire is_conv;
	wire is_ext0;

	// condition terms of the conversion skip
	wire conv_cond;
	wire conv_skip;

	// condition terms of the pin skip
	wire ext0_level_match;
	wire ext0_skip;

	// either skip taken in this slot
	wire any_skip;

	// a skip owed to the next valid word
	reg skip_pend_r;

	// next value of the owed skip
	reg skip_pend_nxt;

	// next value of the done flag
	reg flag_nxt;

	// next values of the result pulses
	reg skip_next_nxt;
	reg slot_squash_nxt;
	reg decode_hit_nxt;

	// enable bit consulted by the conversion skip
	assign conversion_irq_enable_bit =
		interrupt_control_reg_two[`STI_CONV_IRQ_EN_BIT];

	// polarity bit consulted by the pin skip
	assign ext0_polarity_bit =
		ext0_control_reg[`STI_EXT0_POL_BIT];

	// a word in a skipped slot decodes to nothing
	assign live = instr_valid & ~skip_pend_r;

	// opcode decode, only for a live slot
	always @* begin
		kind = KIND_NONE;
		if (live) begin
			case (instr_word)
				`STI_OP_SKIP_CONV: begin
					kind = KIND_CONV;
				end
				`STI_OP_SKIP_EXT0: begin
					kind = KIND_EXT0;
				end
				default: begin
					kind = KIND_NONE;
				end
			endcase
		end
	end

	// split the kind into two strobes
	assign is_conv = (kind == KIND_CONV);
	assign is_ext0 = (kind == KIND_EXT0);

	// skip needs the enable clear and the flag set
	assign conv_cond = ~conversion_irq_enable_bit
		& conversion_done_flag;

	// enable set makes the conversion skip a no-op
	assign conv_skip = is_conv & conv_cond;

	// pin level against the level chosen by polarity
	assign ext0_level_match = ext0_polarity_bit ?
		ext0_interrupt_pin : ~ext0_interrupt_pin;

	// pin skip taken on a level match
	assign ext0_skip = is_ext0 & ext0_level_match;

	// any skip owes the next word a squash
	assign any_skip = conv_skip | ext0_skip;

	// flag next value: a set from the converter wins
	always @* begin
		flag_nxt = conversion_done_flag;
		if (conversion_done_set) begin
			flag_nxt = 1'b1;
		end else if (conv_skip) begin
			flag_nxt = 1'b0;
		end
	end

	// owed skip survives cycles with no word
	always @* begin
		skip_pend_nxt = skip_pend_r;
		if (any_skip) begin
			skip_pend_nxt = 1'b1;
		end else if (instr_valid) begin
			skip_pend_nxt = 1'b0;
		end
	end

	// skip pulse for the word just taken
	always @* begin
		skip_next_nxt = any_skip;
	end

	// squash pulse for a word in an owed slot
	always @* begin
		slot_squash_nxt = instr_valid & skip_pend_r;
	end

	// hit pulse for a live skip word of either kind
	always @* begin
		decode_hit_nxt = is_conv | is_ext0;
	end

	// done flag register
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			conversion_done_flag <= 1'b0;
		end else begin
			conversion_done_flag <= flag_nxt;
		end
	end

	// owed skip register
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			skip_pend_r <= 1'b0;
		end else begin
			skip_pend_r <= skip_pend_nxt;
		end
	end

	// skip pulse register
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			skip_next <= 1'b0;
		end else begin
			skip_next <= skip_next_nxt;
		end
	end

	// squash pulse register
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			slot_squash <= 1'b0;
		end else begin
			slot_squash <= slot_squash_nxt;
		end
	end

	// hit pulse register
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			decode_hit <= 1'b0;
		end else begin
			decode_hit <= decode_hit_nxt;
		end
	end

	// outputs all leave from the registers above
	// so the core sees them one edge after the word
	// and never through a combinational path

endmodule // sti_skip_decode
`default_nettype wire

//--- testbench/sti_skip_decode_asserts.sv
// checker for the skip-test decoder
`timescale 1ns/1ps
`default_nettype none
module sti_skip_chk(input wire clk_sys,nrst,instr_valid,ext0_interrupt_pin,
	input wire [9:0] instr_word,input wire [3:0] interrupt_control_reg_two,
	input wire [3:0] ext0_control_reg,input wire conversion_done_set,
	input wire conversion_done_flag,skip_next,slot_squash,decode_hit);
default clocking @(posedge clk_sys); endclocking
default disable iff (!nrst);
// skip still owed after idle cycles
reg hold_r;
always @(posedge clk_sys or negedge nrst)
	if (!nrst) hold_r<=1'b0;
	else hold_r<=!instr_valid&&(skip_next||hold_r);
// live decode of each skip word
wire pend=skip_next||hold_r;
wire ok=instr_valid&&!pend;
wire cv=ok&&instr_word==10'h287&&!conversion_done_set;
wire px=ok&&instr_word==10'h03a;
wire ie=interrupt_control_reg_two[2];
wire pol=ext0_control_reg[2];
wire pin=ext0_interrupt_pin;
wire f=conversion_done_flag;
wire other=instr_valid&&instr_word!=10'h287&&instr_word!=10'h03a;
AST_CONV_SKIP: assert property (cv&&!ie&&f |=> skip_next&&decode_hit&&!f)
	else $error("conversion skip not taken");
AST_CONV_RUN: assert property (cv&&!ie&&!f |=> decode_hit&&!skip_next&&!f)
	else $error("conversion skip taken with flag clear");
AST_CONV_NOP: assert property (cv&&ie |=> decode_hit&&!skip_next&&$stable(f))
	else $error("conversion skip not a no-op");
AST_EXT0_LOW: assert property (px&&!pol |=> skip_next!=$past(pin))
	else $error("ext0 low-level skip wrong");
AST_EXT0_HIGH: assert property (px&&pol |=> skip_next==$past(pin))
	else $error("ext0 high-level skip wrong");
AST_SQUASH: assert property (instr_valid&&pend |=> slot_squash&&!decode_hit)
	else $error("skipped slot not squashed");
AST_SLOT_FLAG: assert property (instr_valid&&pend&&f |=> f)
	else $error("skipped slot changed the flag");
AST_SET_WINS: assert property (conversion_done_set |=> f)
	else $error("flag set lost");
AST_NO_HIT: assert property (other |=> !decode_hit&&!skip_next)
	else $error("other word decoded as a skip");
cover property (skip_next&&f);
cover property (slot_squash);
cover property (decode_hit&&!skip_next);
endmodule // sti_skip_chk
bind sti_skip_decode sti_skip_chk chk(.*);
`default_nettype wire

//--- testbench/sti_skip_decode_tb.sv
// self-checking bench for the skip-test decoder
`timescale 1ns/1ps
`default_nettype none
module sti_skip_decode_tb;
logic clk_sys=0,nrst=0,v=0,p=0,d=0,fl,sk,sq,dh;
logic [9:0] w=0;
logic [3:0] e=0;
int err_count=0,checked=0,cyc=0;
sti_skip_decode dut(.clk_sys(clk_sys),.nrst(nrst),.instr_valid(v),
	.instr_word(w),.interrupt_control_reg_two(e),.ext0_control_reg(e),
	.ext0_interrupt_pin(p),.conversion_done_set(d),
	.conversion_done_flag(fl),.skip_next(sk),.slot_squash(sq),.decode_hit(dh));
initial forever #2.5 clk_sys=~clk_sys;
task c(input string n,input x,input y);
	checked++;
	if (x!==y) begin
		err_count++;
		$display("[ERR] %s exp %0b got %0b",n,y,x);
	end
endtask
// optional flag set, one word, then a filler word that may be squashed
task t(input [9:0] a,input [3:0] b,input q,input s,input k,input g);
	d=s;
	@(posedge clk_sys) #1 d=0; w=a; e=b; p=q; v=1;
	@(posedge clk_sys) #1 w=0;
	c("skip",sk,k);
	c("flag",fl,g);
	c("hit",dh,1);
	@(posedge clk_sys) #1 v=0;
	c("squash",sq,k);
	$display("test %h done",a);
endtask
// converter set during a taken skip, then a skip word in the owed slot
task tw;
	d=1;
	@(posedge clk_sys) #1 w=10'h287; e=0; v=1;
	@(posedge clk_sys) #1 d=0; v=0;
	c("skip",sk,1);
	c("flag",fl,1);
	@(posedge clk_sys) #1 v=1;
	@(posedge clk_sys) #1 v=0;
	c("squash",sq,1);
	c("hit",dh,0);
	c("flag",fl,1);
	$display("test set-wins done");
endtask
// reset in mid-run clears the flag and the skip pulse
task tr;
	nrst=0;
	@(posedge clk_sys) #1 c("flag",fl,0);
	c("skip",sk,0);
	nrst=1;
	$display("test reset done");
endtask
task results;
	$display("checks %0d errors %0d",checked,err_count);
	if (err_count==0&&checked>0) $display("Run complete: PASS");
	else $display("Run complete: FAIL");
	$finish;
endtask
always @(posedge clk_sys) if (++cyc==400) begin err_count++; results; end
initial begin
	repeat (5) @(posedge clk_sys);
	#1 nrst=1;
	t(10'h287,0,0,1,1,0);
	t(10'h287,0,0,0,0,0);
	t(10'h287,4,0,1,0,1);
	t(10'h03a,0,0,0,1,1);
	t(10'h03a,0,1,0,0,1);
	t(10'h03a,4,1,0,1,1);
	t(10'h03a,4,0,0,0,1);
	tw;
	tr;
	t(10'h03a,0,0,0,1,0);
	results;
end
endmodule // sti_skip_decode_tb
`default_nettype wire
